//--- common/svm_pkg.sv
// package: constants for the supply voltage monitor control block
package svm_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR  = 8'hA9;
  localparam logic [7:0] LEVEL_ADDR = 8'hAA;
  localparam logic [7:0] RESET_SOURCE_REG_ADDR  = 8'hAB;
  // control register fields
  localparam int CTRL_WEN_BIT  = 7;
  localparam int CTRL_MASK_BIT = 1;
  localparam int CTRL_FLAG_BIT = 0;
  // level register fields
  localparam int LVL_MODE_BIT = 7;
  localparam int LVL_LOW_BIT  = 0;
  // reset source register field
  localparam int RESET_SOURCE_REG_DET_BIT = 0;
  // reset values of the level register per mode
  localparam logic [7:0] LVL_RST_COMBINED  = 8'h00;
  localparam logic [7:0] LVL_RST_RESETONLY = 8'h81;
  localparam logic [7:0] LVL_RST_IRQONLY   = 8'h01;
  localparam logic [7:0] CTRL_RST          = 8'h00;
  localparam logic [7:0] ZERO8             = 8'h00;
  // ------------------------------------------------------------
  // modes from the configuration pins {hi, lo}
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_COMBINED  = 2'b10;
  localparam logic [1:0] MODE_RESETONLY = 2'b11;
  localparam logic [1:0] MODE_IRQONLY   = 2'b01;
  // ------------------------------------------------------------
  // timing at 25 MHz
  // ------------------------------------------------------------
  localparam int CLOCK_MHZ        = 25;
  localparam int RESET_PROC_MIN_US = 497;
  localparam int RESET_PROC_MAX_US = 720;
  // least time rounds up; 497 us * 25 = 12425 cycles
  localparam int RESET_PROC_CYCLES = RESET_PROC_MIN_US * CLOCK_MHZ;
  localparam int SETTLE_CYCLES_DEF = 16;
  localparam int NUM_LEVELS        = 6;
endpackage : svm_pkg

//--- src/reset_timer.sv
// reset processing interval counter
`timescale 1ns/1ns
module reset_timer #(
  parameter int COUNT = 12425
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // control
  input  wire logic holdIn,
  output logic      busy
);
  logic [15:0] countReg;
  logic [15:0] countNext;
  localparam logic [15:0] LOAD = 16'(COUNT);
  localparam logic [15:0] ONE  = 16'h0001;
  localparam logic [15:0] NIL  = 16'h0000;

  // reload while held, count down after release
  assign countNext = holdIn ? LOAD : ((countReg != NIL) ? countReg - ONE : NIL);
  assign busy      = holdIn || (countReg != NIL);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      countReg <= LOAD;
    end else begin
      countReg <= countNext;
    end
  end
endmodule : reset_timer

//--- src/supply_voltage_monitor_ctrl.sv
// supply voltage monitor control: modes, registers, reset and interrupt generation
//
// Functional notes
// - after internal reset release, hold cpu start for the processing interval
// - mode pins: 10 combined, 11 reset only, 01 interrupt only
// - one of 6 levels chosen by config at start-up, not by writes
// - combined: interrupt below high level, reset below low level
// - combined: release detector reset only at or above high level
// - reset only: reset while below level, release at or above
// - interrupt only: initial reset held until supply first reaches level
// - interrupt only: afterwards interrupt on every crossing either way
// - control bit 0 reads 1 below threshold, 0 otherwise or disabled
// - detector reset sets the detector reset-source flag, except the interrupt-only start-up hold
// - control: enable bit 7, mask bit 1, flag bit 0, rest zero
// - enable gates level writes; settable only in combined mode
// - mask set while enable, after interrupt, after level change
// - detector reset keeps control; other resets clear bit 7 only
// - other resets load level register 00h, 81h or 01h by mode
// - level writes only in combined mode; keeps its reset value in the other modes
// - combined: first interrupt sets low select and reset mode bits
// - level bit 7 reset mode, bit 0 selects low level
`timescale 1ns/1ns
module supply_voltage_monitor_ctrl #(
  parameter int RESET_CYCLES  = svm_pkg::RESET_PROC_CYCLES,
  parameter int SETTLE_CYCLES = svm_pkg::SETTLE_CYCLES_DEF
) (
  // clock and system reset (other sources than the detector)
  input  wire logic       clock,
  input  wire logic       rst,
  // non-volatile configuration
  input  wire logic       cfgModeHi,
  input  wire logic       cfgModeLo,
  input  wire logic       cfgDisable,
  input  wire logic [1:0] cfgLevelSel,
  // analogue comparators, high when supply is below each level
  input  wire logic       belowHighAsync,
  input  wire logic       belowLowAsync,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdData,
  // system outputs
  output logic            detectorReset,
  output logic            detectorIrq,
  output logic            cpuHold,
  output logic      [2:0] levelSelectOut
);
  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;
  logic       belowHigh;
  logic       belowLow;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncA_reg <= 2'h0;
      syncB_reg <= 2'h0;
    end else begin
      syncA_reg <= {belowLowAsync, belowHighAsync};
      syncB_reg <= syncA_reg;
    end
  end
  assign belowHigh = syncB_reg[0];
  assign belowLow  = syncB_reg[1];

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic [1:0] mode;
  logic       isCombined;
  logic       isResetOnly;
  logic       isIrqOnly;
  logic       enabled;
  assign mode        = {cfgModeHi, cfgModeLo};
  assign isCombined  = (mode == svm_pkg::MODE_COMBINED);
  assign isResetOnly = (mode == svm_pkg::MODE_RESETONLY);
  assign isIrqOnly   = (mode == svm_pkg::MODE_IRQONLY);
  assign enabled     = !cfgDisable && (isCombined || isResetOnly || isIrqOnly);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic       levelWen_reg;
  logic       levelWen_next;
  logic [7:0] level_reg;
  logic [7:0] level_next;
  logic       detReset_reg;
  logic       detReset_next;
  logic       resetSrc_reg;
  logic       resetSrc_next;
  logic       irqDone_reg;
  logic       irqDone_next;
  logic       started_reg;
  logic       primed_reg;
  logic       prevBelow_reg;
  logic [7:0] settle_reg;
  logic [7:0] settle_next;
  logic       irq_reg;
  logic       irq_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic [7:0] levelInit;

  localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYCLES);
  localparam logic [7:0] ONE8        = 8'h01;

  // level select is latched from the configuration once after reset
  logic [1:0] levelCfg_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      levelCfg_reg <= 2'h0;
      started_reg  <= 1'b0;
      primed_reg   <= 1'b0;
    end else begin
      started_reg  <= 1'b1;
      primed_reg   <= started_reg;
      if (!started_reg) begin
        levelCfg_reg <= cfgLevelSel;
      end
    end
  end
  assign levelSelectOut = {levelCfg_reg, level_reg[svm_pkg::LVL_LOW_BIT]};

  // ------------------------------------------------------------
  // detection and masking
  // ------------------------------------------------------------
  logic lowSelected;
  logic below;
  logic masked;
  logic crossing;
  logic irqEvent;
  logic resetCause;
  logic resetRelease;
  logic levelWrite;
  logic levelChanged;
  assign lowSelected = level_reg[svm_pkg::LVL_LOW_BIT];
  // combined uses the level bit; single-level modes use the high comparator
  assign below       = enabled && (isCombined && lowSelected ? belowLow : belowHigh);
  assign masked      = levelWen_reg || (settle_reg != svm_pkg::ZERO8);
  assign crossing    = started_reg && (below != prevBelow_reg);

  // interrupt events per mode
  assign irqEvent = !masked && !detReset_reg && crossing && (
                    (isCombined && below && !level_reg[svm_pkg::LVL_MODE_BIT]) ||
                    (isIrqOnly && irqDone_reg));
  // reset cause and release per mode
  assign resetCause   = enabled && !masked && (
                        (isCombined && belowLow) ||
                        (isResetOnly && belowHigh));
  assign resetRelease = !belowHigh;

  assign levelWrite   = wrStb && (addr == svm_pkg::LEVEL_ADDR) && levelWen_reg
                        && isCombined;
  assign levelChanged = level_next[svm_pkg::LVL_LOW_BIT] != level_reg[svm_pkg::LVL_LOW_BIT];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    levelWen_next = levelWen_reg;
    if (wrStb && (addr == svm_pkg::CTRL_ADDR)) begin
      levelWen_next = wrData[svm_pkg::CTRL_WEN_BIT] && isCombined;
    end
  end

  always_comb begin
    level_next = level_reg;
    if (levelWrite) begin
      level_next = wrData;
    end
    if (irqEvent && isCombined) begin
      level_next[svm_pkg::LVL_LOW_BIT]  = 1'b1;
      level_next[svm_pkg::LVL_MODE_BIT] = 1'b1;
    end
  end

  always_comb begin
    detReset_next = detReset_reg;
    if (resetCause) begin
      detReset_next = 1'b1;
    end else if (detReset_reg && resetRelease) begin
      detReset_next = 1'b0;
    end
  end

  // the flag only ever sets here, so no clear can race with it
  assign resetSrc_next = resetSrc_reg || (resetCause && !detReset_reg);
  // synchroniser output holds its reset value until primed, so no early release
  assign irqDone_next  = irqDone_reg || (isIrqOnly && primed_reg && !belowHigh);
  assign irq_next      = irqEvent;

  always_comb begin
    settle_next = (settle_reg != svm_pkg::ZERO8) ? settle_reg - ONE8 : svm_pkg::ZERO8;
    if (irqEvent || levelChanged) begin
      settle_next = SETTLE_LOAD;
    end
  end

  always_comb begin
    case (mode)
      svm_pkg::MODE_COMBINED:  levelInit = svm_pkg::LVL_RST_COMBINED;
      svm_pkg::MODE_RESETONLY: levelInit = svm_pkg::LVL_RST_RESETONLY;
      default:                 levelInit = svm_pkg::LVL_RST_IRQONLY;
    endcase
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [7:0] ctrlView;
  assign ctrlView = {levelWen_reg, 5'h00, masked, below};
  always_comb begin
    rdData_next = svm_pkg::ZERO8;
    if (rdStb) begin
      case (addr)
        svm_pkg::CTRL_ADDR:  rdData_next = ctrlView;
        svm_pkg::LEVEL_ADDR: rdData_next = level_reg;
        svm_pkg::RESET_SOURCE_REG_ADDR:  rdData_next = {7'h00, resetSrc_reg};
        default:             rdData_next = svm_pkg::ZERO8;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers; system reset clears only bit 7 of control
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      levelWen_reg  <= 1'b0;
      detReset_reg  <= 1'b0;
      resetSrc_reg  <= 1'b0;
      irqDone_reg   <= 1'b0;
      prevBelow_reg <= 1'b0;
      settle_reg    <= svm_pkg::ZERO8;
      irq_reg       <= 1'b0;
      rdData_reg    <= svm_pkg::ZERO8;
    end else begin
      levelWen_reg  <= levelWen_next;
      detReset_reg  <= detReset_next;
      resetSrc_reg  <= resetSrc_next;
      irqDone_reg   <= irqDone_next;
      prevBelow_reg <= below;
      settle_reg    <= settle_next;
      irq_reg       <= irq_next;
      rdData_reg    <= rdData_next;
    end
  end

  // level register: loaded from the mode one cycle after system reset,
  // and untouched by the detector's own reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_reg <= svm_pkg::ZERO8;
    end else if (!started_reg) begin
      level_reg <= levelInit;
    end else begin
      level_reg <= level_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  reset_timer #(
    .COUNT (RESET_CYCLES)
  ) u_reset_timer (
    .clock  (clock),
    .rst    (rst),
    .holdIn (detectorReset),
    .busy   (cpuHold)
  );
  // interrupt-only mode also holds reset from start until the level is first reached
  assign detectorReset = detReset_reg || (enabled && isIrqOnly && !irqDone_reg);
  assign detectorIrq   = irq_reg;
  assign rdData        = rdData_reg;
endmodule : supply_voltage_monitor_ctrl

//--- tb/supply_model.sv
// comparator model: turns a supply step into the two comparator outputs
`timescale 1ns/1ns
module supply_model (
  // supply step: 0 above high level, 1 between levels, 2 below low level
  input  wire logic [1:0] step,
  // comparator outputs, high while the supply is below each level
  output logic            belowHighAsync,
  output logic            belowLowAsync
);
  // outputs move off the clock edge, as a free-running comparator would
  assign #7 belowHighAsync = (step != 2'h0);
  assign #7 belowLowAsync  = (step == 2'h2);
endmodule : supply_model

//--- tb/supply_monitor_checker.sv
// checker: port-level assertions for the supply monitor control block
`timescale 1ns/1ns
module supply_monitor_checker #(
  parameter int RESET_CYCLES = 20
) (
  // clock, reset and configuration
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       cfgModeHi,
  input wire logic       cfgModeLo,
  input wire logic       cfgDisable,
  input wire logic [1:0] cfgLevelSel,
  // comparators and register port
  input wire logic       belowHighAsync,
  input wire logic       belowLowAsync,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] rdData,
  // system outputs
  input wire logic       detectorReset,
  input wire logic       detectorIrq,
  input wire logic       cpuHold,
  input wire logic [2:0] levelSelectOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  int holdCnt;
  // counts hold cycles after a detector reset ends; idle at 0 otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) holdCnt <= 0;
    else if (detectorReset) holdCnt <= 1;
    else if (!cpuHold) holdCnt <= 0;
    else if (holdCnt != 0) holdCnt <= holdCnt + 1;
  end
  chk_irq_single: assert property (detectorIrq |=> !detectorIrq)
    else $error("irq pulse longer than one cycle");
  chk_rd_idle: assert property (!rdStb |=> rdData == 8'h00)
    else $error("read data not zero outside read slot");
  chk_ctrl_zero: assert property (rdStb && addr == svm_pkg::CTRL_ADDR |=> rdData[6:2] == 5'h00)
    else $error("control bits 6..2 not zero");
  chk_hold_cover: assert property (detectorReset |-> cpuHold)
    else $error("cpu not held during detector reset");
  chk_hold_len: assert property ($fell(cpuHold) && holdCnt != 0
      |-> holdCnt >= RESET_CYCLES && holdCnt <= RESET_CYCLES + 3)
    else $error("cpu hold length after detector reset wrong");
  // two synchroniser stages plus the start-up stage give up to four edges of latency
  chk_reset_release: assert property ((!belowHighAsync) [*5] |-> !detectorReset)
    else $error("detector reset held with supply above high level");
  chk_reset_only: assert property ((cfgModeHi && cfgModeLo && !cfgDisable && belowHighAsync) [*5]
      |-> detectorReset)
    else $error("reset-only mode missed a reset");
  chk_no_irq_rst: assert property (cfgModeHi && cfgModeLo |-> !detectorIrq)
    else $error("interrupt in reset-only mode");
  chk_flag_off: assert property (cfgDisable && rdStb && addr == svm_pkg::CTRL_ADDR
      |=> !rdData[0])
    else $error("flag set with detector disabled");
endmodule : supply_monitor_checker

bind supply_voltage_monitor_ctrl supply_monitor_checker #(.RESET_CYCLES(RESET_CYCLES)) i_chk (
  .clock, .rst, .cfgModeHi, .cfgModeLo, .cfgDisable, .cfgLevelSel, .belowHighAsync,
  .belowLowAsync, .addr, .wrData, .wrStb, .rdStb, .rdData, .detectorReset, .detectorIrq,
  .cpuHold, .levelSelectOut
);

//--- tb/tb_supply_voltage_monitor_ctrl.sv
// testbench: register and supply scenarios for the supply monitor control block
`timescale 1ns/1ns
module tb_supply_voltage_monitor_ctrl;
  localparam logic [7:0] CT = svm_pkg::CTRL_ADDR;
  localparam logic [7:0] LV = svm_pkg::LEVEL_ADDR;
  localparam logic [7:0] RF = svm_pkg::RESET_SOURCE_REG_ADDR;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       cfgModeHi = 1'b1;
  logic       cfgModeLo = 1'b0;
  logic       cfgDisable = 1'b0;
  logic [1:0] cfgLevelSel = 2'h2;
  logic [1:0] step = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic       wrStb = 1'b0;
  logic       rdStb = 1'b0;
  logic       belowHighAsync, belowLowAsync, detectorReset, detectorIrq, cpuHold;
  logic [7:0] rdData;
  logic [2:0] levelSelectOut;
  int         errorCnt = 0;
  int         testsRun = 0;
  int         irqCnt = 0;
  int         cycles = 0;
  int         n;
  supply_model i_supply (.step, .belowHighAsync, .belowLowAsync);
  supply_voltage_monitor_ctrl #(.RESET_CYCLES(20), .SETTLE_CYCLES(4)) i_dut (
    .clock, .rst, .cfgModeHi, .cfgModeLo, .cfgDisable, .cfgLevelSel, .belowHighAsync,
    .belowLowAsync, .addr, .wrData, .wrStb, .rdStb, .rdData, .detectorReset, .detectorIrq,
    .cpuHold, .levelSelectOut
  );
  initial forever #20 clock = ~clock;
  always @(posedge clock) begin
    if (detectorIrq === 1'b1) irqCnt <= irqCnt + 1;
    cycles <= cycles + 1;
    // the whole run needs well under a thousand cycles
    if (cycles == 3000) begin
      errorCnt++;
      conclude();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // step off the edge so outputs launched by it have settled before they are read
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1 check(rdData, exp);
  endtask : rd
  // mode pins only change under system reset, as they do at start-up
  task automatic boot(input logic hi, input logic lo, input logic dis, input logic [1:0] s);
    @(posedge clock);
    rst <= 1'b1;
    cfgModeHi <= hi;
    cfgModeLo <= lo;
    cfgDisable <= dis;
    step <= s;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    cyc(2);
  endtask : boot
  task automatic conclude();
    $display("tests run %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial begin
    boot(1'b1, 1'b0, 1'b0, 2'h0);
    check({5'h00, levelSelectOut}, 8'h04);
    cfgLevelSel <= 2'h1;
    rd(CT, 8'h00);
    rd(LV, 8'h00);
    rd(8'h55, 8'h00);
    wr(LV, 8'h81);
    rd(LV, 8'h00);
    wr(CT, 8'hFF);
    rd(CT, 8'h82);
    wr(LV, 8'h81);
    rd(LV, 8'h81);
    wr(LV, 8'h00);
    wr(CT, 8'h00);
    cyc(10);
    rd(CT, 8'h00);
    n = irqCnt;
    step <= 2'h1;
    cyc(10);
    check(8'(irqCnt - n), 8'h01);
    check({7'h00, detectorReset}, 8'h00);
    rd(LV, 8'h81);
    check({5'h00, levelSelectOut}, 8'h05);
    step <= 2'h2;
    cyc(10);
    check({7'h00, detectorReset}, 8'h01);
    check(8'(irqCnt - n), 8'h01);
    step <= 2'h1;
    cyc(10);
    check({7'h00, detectorReset}, 8'h01);
    step <= 2'h0;
    cyc(10);
    check({7'h00, detectorReset}, 8'h00);
    check({7'h00, cpuHold}, 8'h01);
    cyc(20);
    check({7'h00, cpuHold}, 8'h00);
    rd(RF, 8'h01);
    rd(LV, 8'h81);
    rd(CT, 8'h00);
    wr(CT, 8'h80);
    boot(1'b1, 1'b0, 1'b0, 2'h0);
    rd(CT, 8'h00);
    rd(LV, 8'h00);
    rd(RF, 8'h00);
    $display("combined mode test done");
    boot(1'b1, 1'b1, 1'b0, 2'h0);
    rd(LV, 8'h81);
    wr(CT, 8'h80);
    rd(CT, 8'h00);
    wr(LV, 8'h00);
    rd(LV, 8'h81);
    step <= 2'h1;
    cyc(10);
    check({7'h00, detectorReset}, 8'h01);
    rd(CT, 8'h01);
    step <= 2'h0;
    cyc(10);
    check({7'h00, detectorReset}, 8'h00);
    rd(RF, 8'h01);
    $display("reset-only mode test done");
    boot(1'b0, 1'b1, 1'b0, 2'h1);
    check({7'h00, detectorReset}, 8'h01);
    rd(LV, 8'h01);
    step <= 2'h0;
    cyc(10);
    check({7'h00, detectorReset}, 8'h00);
    n = irqCnt;
    step <= 2'h1;
    cyc(10);
    step <= 2'h0;
    cyc(10);
    check(8'(irqCnt - n), 8'h02);
    $display("interrupt-only mode test done");
    boot(1'b1, 1'b0, 1'b1, 2'h2);
    cyc(10);
    rd(CT, 8'h00);
    check({7'h00, detectorReset}, 8'h00);
    $display("disabled detector test done");
    conclude();
  end
endmodule : tb_supply_voltage_monitor_ctrl
